// File: core/irq_map_regs.vh
// Constants for the interrupt request and vector map block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef IRQ_MAP_REGS_VH
`define IRQ_MAP_REGS_VH

// Register byte offsets.
`define REG_FLAG        8'h00
`define REG_ENABLE      8'h04
`define REG_CTRL        8'h08
`define REG_STATUS      8'h0c
`define REG_IRQ_STAT    8'h10
`define REG_IRQ_MASK    8'h14

// Control register fields.
`define CTRL_GIE_BIT    0
`define CTRL_SPLIT_BIT  1

// Status event fields.
`define EV_REQ_BIT      0
`define EV_NMI_BIT      1

// Reset values.
`define FLAG_RESET      26'h0000000
`define ENABLE_RESET    26'h0000000
`define CTRL_RESET      2'h0

// Vector numbers.
`define VEC_RESET       5'h00
`define VEC_NMI         5'h01
`define VEC_PORT_C      5'h05
`define VEC_TA_HIGH_UNF 5'h09
`define VEC_LAST        5'h19
`define VEC_COUNT       26
`define PORT_C_MIN_PINS 20

`endif

// File: core/vector_pick.v
// Lowest-numbered pending vector finder.
// Assumes pending bits are already gated by enables and global enable.
`timescale 1ns/10ps
module vector_pick #(
  parameter N = 26
) (
  // Pending requests
  input  wire [N-1:0] pending_i,
  // Chosen vector
  output reg          any_o,
  output reg  [4:0]   vec_o
);
  integer k;
  always @* begin
    any_o = 1'b0;
    vec_o = 5'h00;
    // Scanning downward lets the lowest pending index win.
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (pending_i[k]) begin
        any_o = 1'b1;
        vec_o = k[4:0];
      end
    end
  end
endmodule // vector_pick

// File: core/irq_vector_map.v
// Interrupt request former and vector map for the on-chip peripherals.
// Assumes one 40 MHz clock, synchronous reset and a classic Wishbone
// master; peripheral event inputs are one-cycle pulses on clk_i.
// How it works
// - Peripheral event sets its flag bit
// - Software writes and holds each enable bit
// - Request only when enable and flag set
// - Request holds until flag is cleared
// - Global enable gates all maskable requests
// - One source per vector, address equals number
// - Vector 1 is unmasked memory scan interrupt
// - Vectors 2-5: monitor, ports A, B, C
// - Vectors 6, 7: counter and periodic timer
// - Vector 8/9: timer A overflow or split underflows
// - Vectors 10-12: timer A compare channels
// - Vector 13 timer B, 14-15 timer D
// - Vectors 16-18: comparator, converter result, window
// - Vectors 19-21: two-wire client, host, SPI
// - Vectors 22-24: serial receive, empty, transmit
// - Vector 25 is EEPROM ready
// - Port C vector only with 20+ pins
`timescale 1ns/10ps
`include "irq_map_regs.vh"
module irq_vector_map #(
  parameter PIN_COUNT = 24
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Peripheral event pulses
  input  wire        memory_scan_nonmaskable_vec_i,
  input  wire        voltage_level_monitor_vec_i,
  input  wire        port_a_pin_vec_i,
  input  wire        port_b_pin_vec_i,
  input  wire        port_c_pin_vec_i,
  input  wire        realtime_counter_vec_i,
  input  wire        periodic_timer_vec_i,
  input  wire        timer_a_overflow_vec_i,
  input  wire        timer_a_low_underflow_vec_i,
  input  wire        timer_a_high_underflow_vec_i,
  input  wire [2:0]  timer_a_compare_vec_i,
  input  wire [2:0]  timer_a_low_compare_vec_i,
  input  wire        timer_b_capture_vec_i,
  input  wire        timer_d_overflow_vec_i,
  input  wire        timer_d_trigger_vec_i,
  input  wire        comparator_vec_i,
  input  wire        converter_result_vec_i,
  input  wire        converter_window_vec_i,
  input  wire        two_wire_client_vec_i,
  input  wire        two_wire_host_vec_i,
  input  wire        serial_periph_vec_i,
  input  wire        serial_port_rx_done_vec_i,
  input  wire        serial_port_tx_empty_vec_i,
  input  wire        serial_port_tx_done_vec_i,
  input  wire        eeprom_ready_vec_i,
  // Processor core side
  input  wire        ack_vec_i,
  output reg         req_o,
  output reg  [4:0]  vec_o,
  output reg  [4:0]  word_addr_o,
  output reg         nmi_o,
  output wire        irq_o
);
  localparam N = `VEC_COUNT;
  localparam [0:0] HAS_PORT_C = (PIN_COUNT >= `PORT_C_MIN_PINS);

  reg  [N-1:0] peripheral_flag_register;
  reg  [N-1:0] peripheral_enable_register;
  reg  [1:0]   ctrl;
  reg  [1:0]   irq_stat;
  reg  [1:0]   irq_mask;
  reg  [N-1:0] event_in;
  reg  [N-1:0] exist;
  reg  [N-1:0] next_flag;
  wire [N-1:0] pending;
  wire [N-1:0] gated;
  wire         any_pending;
  wire [4:0]   pick_vec;
  wire         split = ctrl[`CTRL_SPLIT_BIT];
  wire         gie = ctrl[`CTRL_GIE_BIT];
  // A write lands at the edge where the master samples ack high, so a
  // request that is still held over its wait state is applied only once.
  wire         wr = cyc_i & stb_i & we_i & ack_o;
  wire         rd = cyc_i & stb_i & ~we_i & ~ack_o;
  wire [N-1:0] wdat = dat_i[N-1:0];
  wire [N-1:0] lane_mask = {{2{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                            {8{sel_i[0]}}};

  // Fixed source to vector wiring; vector 0 is reset and has no flag.
  always @* begin
    event_in     = {N{1'b0}};
    event_in[1]  = memory_scan_nonmaskable_vec_i;
    event_in[2]  = voltage_level_monitor_vec_i;
    event_in[3]  = port_a_pin_vec_i;
    event_in[4]  = port_b_pin_vec_i;
    event_in[5]  = port_c_pin_vec_i & HAS_PORT_C;
    event_in[6]  = realtime_counter_vec_i;
    event_in[7]  = periodic_timer_vec_i;
    // Split mode changes which timer A event owns vectors 8 to 12.
    event_in[8]  = split ? timer_a_low_underflow_vec_i
                         : timer_a_overflow_vec_i;
    event_in[9]  = split & timer_a_high_underflow_vec_i;
    event_in[12:10] = split ? timer_a_low_compare_vec_i
                            : timer_a_compare_vec_i;
    event_in[13] = timer_b_capture_vec_i;
    event_in[14] = timer_d_overflow_vec_i;
    event_in[15] = timer_d_trigger_vec_i;
    event_in[16] = comparator_vec_i;
    event_in[17] = converter_result_vec_i;
    event_in[18] = converter_window_vec_i;
    event_in[19] = two_wire_client_vec_i;
    event_in[20] = two_wire_host_vec_i;
    event_in[21] = serial_periph_vec_i;
    event_in[22] = serial_port_rx_done_vec_i;
    event_in[23] = serial_port_tx_empty_vec_i;
    event_in[24] = serial_port_tx_done_vec_i;
    event_in[25] = eeprom_ready_vec_i;
  end

  // Vectors with a source in this build and split mode; others never hold a flag bit.
  always @* begin
    exist    = {N{1'b1}};
    exist[0] = 1'b0;
    exist[5] = HAS_PORT_C;
    exist[9] = split;
  end

  // A write of one clears a flag, but an event in the same cycle wins.
  always @* begin
    next_flag = peripheral_flag_register;
    if (wr && adr_i == `REG_FLAG)
      next_flag = next_flag & ~(wdat & lane_mask);
    next_flag = (next_flag | event_in) & exist;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_flag_register   <= `FLAG_RESET;
      peripheral_enable_register <= `ENABLE_RESET;
      ctrl                       <= `CTRL_RESET;
    end else begin
      peripheral_flag_register <= next_flag;
      if (wr && adr_i == `REG_ENABLE)
        peripheral_enable_register <= (peripheral_enable_register &
          ~lane_mask) | (wdat & lane_mask & exist);
      if (wr && adr_i == `REG_CTRL && sel_i[0])
        ctrl <= dat_i[1:0];
    end
  end

  // Vector 1 bypasses the enables and the global enable.
  assign pending = peripheral_flag_register &
                   (peripheral_enable_register |
                    {{(N-2){1'b0}}, 2'b10});
  assign gated = pending &
                 ({N{gie}} | {{(N-2){1'b0}}, 2'b10});

  vector_pick #(
    .N (N)
  ) u_pick (
    .pending_i (gated),
    .any_o     (any_pending),
    .vec_o     (pick_vec)
  );

  // Request lines are registered so the core sees a steady level.
  always @(posedge clk_i) begin
    if (rst_i) begin
      req_o       <= 1'b0;
      vec_o       <= `VEC_RESET;
      word_addr_o <= `VEC_RESET;
      nmi_o       <= 1'b0;
    end else begin
      req_o       <= any_pending;
      vec_o       <= pick_vec;
      word_addr_o <= pick_vec;
      nmi_o       <= gated[1];
    end
  end

  // Status events: new request taken by the core, and nonmaskable seen.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      if (wr && adr_i == `REG_IRQ_MASK && sel_i[0])
        irq_mask <= dat_i[1:0];
      irq_stat <= (irq_stat &
        ~((wr && adr_i == `REG_IRQ_STAT && sel_i[0]) ? dat_i[1:0] : 2'h0))
        | {event_in[1], req_o & ack_vec_i};
    end
  end
  assign irq_o = |(irq_stat & irq_mask);

  // Single-cycle answer; unmapped addresses read zero and are acked.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h00000000;
      if (rd) begin
        case (adr_i)
          `REG_FLAG:     dat_o <= {6'h00, peripheral_flag_register};
          `REG_ENABLE:   dat_o <= {6'h00, peripheral_enable_register};
          `REG_CTRL:     dat_o <= {30'h00000000, ctrl};
          `REG_STATUS:   dat_o <= {21'h000000, nmi_o, pick_vec,
                                   any_pending, 4'h0};
          `REG_IRQ_STAT: dat_o <= {30'h00000000, irq_stat};
          `REG_IRQ_MASK: dat_o <= {30'h00000000, irq_mask};
          default:       dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // irq_vector_map

// File: sim/irq_vector_map_assertions.sv
// Checker for the bus answer, vector outputs and request levels.
// Assumes it is bound to irq_vector_map and sees only its ports.
`timescale 1ns/10ps
module irq_vector_map_assertions (
  // Clock and reset
  input wire       clk_i,
  input wire       rst_i,
  // Watched signals
  input wire       cyc_i,
  input wire       stb_i,
  input wire       ack_o,
  input wire       req_o,
  input wire [4:0] vec_o,
  input wire [4:0] word_addr_o,
  input wire       nmi_o,
  input wire       irq_o,
  input wire       memory_scan_nonmaskable_vec_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_answers: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  a_ack_has_cause: assert property (
    $rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_addr_is_vec: assert property (word_addr_o == vec_o)
    else $error("word address differs from vector");
  a_vec_in_range: assert property (
    req_o |-> vec_o >= 1 && vec_o <= 25)
    else $error("vector out of range");
  a_nmi_follows: assert property (
    memory_scan_nonmaskable_vec_i |-> ##2 nmi_o)
    else $error("scan event did not raise nmi");
  a_req_stays: assert property (
    req_o && !cyc_i && !$past(cyc_i) |=> req_o)
    else $error("request dropped without a write");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> !req_o && !nmi_o && !ack_o && !irq_o)
    else $error("outputs not cleared by reset");
  a_nmi_first: assert property (
    nmi_o |-> req_o && vec_o == 5'h01)
    else $error("nonmaskable vector not presented first");
endmodule // irq_vector_map_assertions

// File: sim/core_fetch_model.sv
// Processor core model that takes the presented vector after a delay.
// Assumes take_i from the bench says whether the core accepts at all.
`timescale 1ns/10ps
module core_fetch_model #(
  parameter DLY = 2
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       take_i,
  input  wire       req_i,
  input  wire [4:0] vec_i,
  output reg        ack_vec_o,
  output reg  [4:0] fetched_vec_o
);
  reg [3:0] cnt;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_vec_o <= 1'b0;
      cnt <= 4'h0;
      fetched_vec_o <= 5'h00;
    end else begin
      ack_vec_o <= 1'b0;
      cnt <= (take_i && req_i && !ack_vec_o) ? cnt + 4'h1 : 4'h0;
      if (take_i && req_i && !ack_vec_o && cnt == DLY) begin
        ack_vec_o <= 1'b1;
        fetched_vec_o <= vec_i;
      end
    end
  end
endmodule // core_fetch_model

// File: sim/interrupt_request_vector_map_bench.sv
// Self-checking bench: vector table, enables, priority, nmi, status.
// Assumes the core model and checker files are compiled before it.
`timescale 1ns/10ps
`include "irq_map_regs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH %0t value differs", $time); end end
module interrupt_request_vector_map_bench;
  reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, take = 0;
  reg [7:0] adr_i = 0;
  reg [3:0] sel_i = 4'hf, lanes = 4'hf;
  reg [31:0] dat_i = 0, rd;
  reg [30:0] ev = 0;
  wire [31:0] dat_o;
  wire ack_o, req_o, nmi_o, irq_o, ack_vec;
  wire [4:0] vec_o, word_addr_o, got;
  integer error_cnt = 0, n_compared = 0, s, r;
  reg [4:0] v;
  // Row layout: split mode, event bit, expected vector.
  reg [10:0] rows [0:27];
  irq_vector_map dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .memory_scan_nonmaskable_vec_i(ev[1]),
    .voltage_level_monitor_vec_i(ev[2]), .port_a_pin_vec_i(ev[3]),
    .port_b_pin_vec_i(ev[4]), .port_c_pin_vec_i(ev[5]),
    .realtime_counter_vec_i(ev[6]), .periodic_timer_vec_i(ev[7]),
    .timer_a_overflow_vec_i(ev[8]), .timer_a_low_underflow_vec_i(ev[26]),
    .timer_a_high_underflow_vec_i(ev[27]),
    .timer_a_compare_vec_i(ev[12:10]), .timer_a_low_compare_vec_i(ev[30:28]),
    .timer_b_capture_vec_i(ev[13]), .timer_d_overflow_vec_i(ev[14]),
    .timer_d_trigger_vec_i(ev[15]), .comparator_vec_i(ev[16]),
    .converter_result_vec_i(ev[17]), .converter_window_vec_i(ev[18]),
    .two_wire_client_vec_i(ev[19]), .two_wire_host_vec_i(ev[20]),
    .serial_periph_vec_i(ev[21]), .serial_port_rx_done_vec_i(ev[22]),
    .serial_port_tx_empty_vec_i(ev[23]), .serial_port_tx_done_vec_i(ev[24]),
    .eeprom_ready_vec_i(ev[25]), .ack_vec_i(ack_vec), .req_o(req_o),
    .vec_o(vec_o), .word_addr_o(word_addr_o), .nmi_o(nmi_o), .irq_o(irq_o));
  core_fetch_model #(.DLY(2)) core_u (.clk_i(clk_i), .rst_i(rst_i),
    .take_i(take), .req_i(req_o), .vec_i(vec_o), .ack_vec_o(ack_vec),
    .fetched_vec_o(got));
  initial forever #12.5 clk_i = ~clk_i;
  task wait_n(input integer n);
    begin repeat (n) @(posedge clk_i); #1; end
  endtask
  // Ack is read before the edge's updates land, so dat_o is the answer.
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      sel_i <= lanes;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      we_i <= 0;
    end
  endtask
  task pulse(input [30:0] m);
    begin
      @(posedge clk_i);
      ev <= m;
      @(posedge clk_i);
      ev <= 0;
      wait_n(2);
    end
  endtask
  // Reset is raised and dropped on rising edges only.
  task do_reset;
    begin
      @(posedge clk_i);
      rst_i <= 1;
      wait_n(1);
      @(posedge clk_i);
      rst_i <= 0;
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin #400000; error_cnt++; end_of_test; end
  initial begin
    rows[0] = {1'h0, 5'h02, 5'h02};
    rows[1] = {1'h0, 5'h03, 5'h03};
    rows[2] = {1'h0, 5'h04, 5'h04};
    rows[3] = {1'h0, 5'h05, 5'h05};
    rows[4] = {1'h0, 5'h06, 5'h06};
    rows[5] = {1'h0, 5'h07, 5'h07};
    rows[6] = {1'h0, 5'h08, 5'h08};
    rows[7] = {1'h0, 5'h0a, 5'h0a};
    rows[8] = {1'h0, 5'h0b, 5'h0b};
    rows[9] = {1'h0, 5'h0c, 5'h0c};
    rows[10] = {1'h0, 5'h0d, 5'h0d};
    rows[11] = {1'h0, 5'h0e, 5'h0e};
    rows[12] = {1'h0, 5'h0f, 5'h0f};
    rows[13] = {1'h0, 5'h10, 5'h10};
    rows[14] = {1'h0, 5'h11, 5'h11};
    rows[15] = {1'h0, 5'h12, 5'h12};
    rows[16] = {1'h0, 5'h13, 5'h13};
    rows[17] = {1'h0, 5'h14, 5'h14};
    rows[18] = {1'h0, 5'h15, 5'h15};
    rows[19] = {1'h0, 5'h16, 5'h16};
    rows[20] = {1'h0, 5'h17, 5'h17};
    rows[21] = {1'h0, 5'h18, 5'h18};
    rows[22] = {1'h0, 5'h19, 5'h19};
    rows[23] = {1'h1, 5'h1a, 5'h08};
    rows[24] = {1'h1, 5'h1b, 5'h09};
    rows[25] = {1'h1, 5'h1c, 5'h0a};
    rows[26] = {1'h1, 5'h1d, 5'h0b};
    rows[27] = {1'h1, 5'h1e, 5'h0c};
    do_reset;
    for (r = 0; r < 28; r++) begin
      v = rows[r][4:0];
      wb(1, `REG_CTRL, {30'h0, rows[r][10], 1'b1});
      wb(1, `REG_ENABLE, 32'h3fffffc);
      pulse(31'h1 << rows[r][9:5]);
      `CHK(req_o, 1'b1)
      `CHK(vec_o, v)
      `CHK(word_addr_o, v)
      wb(1, `REG_FLAG, 32'h1 << v);
      wait_n(2);
      `CHK(req_o, 1'b0)
    end
    // Without split mode the high underflow owns no vector.
    wb(1, `REG_CTRL, 32'h1);
    pulse(31'h1 << 27);
    `CHK(req_o, 1'b0)
    do_reset;
    for (s = 0; s <= 20; s += 4) begin
      wb(0, s[7:0], 0);
      `CHK(rd, 32'h0)
    end
    wb(0, 8'hfc, 0);
    `CHK(rd, 32'h0)
    wb(1, `REG_ENABLE, 32'h3fffdfc);
    wb(0, `REG_ENABLE, 0);
    `CHK(rd, 32'h3fffdfc)
    // Only byte lane 1 is written, so bits 15:8 alone are cleared.
    lanes = 4'h2;
    wb(1, `REG_ENABLE, 0);
    lanes = 4'hf;
    wb(0, `REG_ENABLE, 0);
    `CHK(rd, 32'h3ff00fc)
    pulse(31'h8);
    `CHK(req_o, 1'b0)
    wb(0, `REG_FLAG, 0);
    `CHK(rd, 32'h8)
    wb(1, `REG_CTRL, 1);
    wait_n(2);
    `CHK(req_o, 1'b1)
    wait_n(10);
    `CHK(req_o, 1'b1)
    wb(1, `REG_IRQ_MASK, 1);
    take <= 1;
    wait_n(8);
    `CHK(got, 5'h03)
    `CHK(irq_o, 1'b1)
    wb(1, `REG_IRQ_MASK, 0);
    take <= 0;
    #1;
    `CHK(irq_o, 1'b0)
    wb(1, `REG_IRQ_MASK, 1);
    wb(1, `REG_IRQ_STAT, 1);
    wait_n(1);
    `CHK(irq_o, 1'b0)
    wb(1, `REG_ENABLE, 0);
    wait_n(2);
    `CHK(req_o, 1'b0)
    wb(1, `REG_FLAG, 32'h8);
    wb(1, `REG_ENABLE, 32'h3fffdfc);
    pulse(31'h100080);
    `CHK(vec_o, 5'h07)
    // Status: any pending at bit 4, vector 7 at bits 9:5, no nmi.
    wb(0, `REG_STATUS, 0);
    `CHK(rd, 32'h000000f0)
    wb(1, `REG_FLAG, 32'h80);
    wait_n(2);
    `CHK(vec_o, 5'h14)
    wb(1, `REG_FLAG, 32'h100000);
    wb(1, `REG_CTRL, 0);
    wb(1, `REG_ENABLE, 0);
    pulse(31'h2);
    `CHK(nmi_o, 1'b1)
    `CHK(vec_o, 5'h01)
    wb(0, `REG_IRQ_STAT, 0);
    `CHK(rd, 32'h2)
    wb(1, `REG_FLAG, 32'h2);
    wait_n(2);
    `CHK(nmi_o, 1'b0)
    end_of_test;
  end
endmodule // interrupt_request_vector_map_bench
bind irq_vector_map irq_vector_map_assertions chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .req_o(req_o),
  .vec_o(vec_o), .word_addr_o(word_addr_o), .nmi_o(nmi_o), .irq_o(irq_o),
  .memory_scan_nonmaskable_vec_i(memory_scan_nonmaskable_vec_i));
